// ==== dwt_map.vh ====
// register offsets, field positions, reset values and timing counts for the dual watchdog
`ifndef DWT_MAP_VH
`define DWT_MAP_VH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define DWT_SW_RELOAD 8'h00
`define DWT_SW_VALUE 8'h04
`define DWT_SW_CTRL 8'h08
`define DWT_SW_KICK 8'h0c
`define DWT_SW_FLAG 8'h10
`define DWT_SW_KEY 8'h14
`define DWT_HW_RELOAD 8'h40
`define DWT_HW_VALUE 8'h44
`define DWT_HW_CTRL 8'h48
`define DWT_HW_KICK 8'h4c
`define DWT_HW_FLAG 8'h50
`define DWT_HW_KEY 8'h54
// ----------------------------------------
// fields
// ----------------------------------------
`define DWT_CTRL_IRQ_BIT 0
`define DWT_CTRL_RES_BIT 1
`define DWT_KICK_HW_MSB 7
// ----------------------------------------
// keys and reset values
// ----------------------------------------
`define DWT_KEY_OPEN 32'h1acce551
`define DWT_KEY_CTRL 32'he5331aae
`define DWT_SW_RELOAD_RST 32'hffffffff
`define DWT_HW_RELOAD_RST 32'h0000ffff
`define DWT_SW_CTRL_RST 2'h0
`define DWT_HW_CTRL_RST 2'h3
// ----------------------------------------
// timing
// ----------------------------------------
`define DWT_SW_DIV 8'h04
`endif

// ==== dwt_core.v ====
// one watchdog down counter with underflow flag and reset generation
`timescale 1ns/10ps
module dwt_core #(
	parameter [31:0] INIT = 32'hffffffff
) (
	input wire clk,
	input wire rst_n,
	input wire tick,
	input wire run,
	input wire load,
	input wire [31:0] load_val,
	input wire kick,
	input wire stop,
	input wire res_en,
	output reg [31:0] count_r,
	output reg flag_r,
	output reg wdg_rst_r
);
	// ----------------------------------------
	// counter and flag
	// ----------------------------------------
	wire underflow;
	// a reload in the same cycle pre-empts the underflow
	assign underflow = run & tick & (count_r == 32'h0) & ~load;

	always @(posedge clk) begin
		if (!rst_n) begin
			count_r <= INIT;
			flag_r <= 1'b0;
			wdg_rst_r <= 1'b0;
		end else begin
			if (load) begin
				count_r <= load_val;
			end else if (run & tick) begin
				if (count_r == 32'h0) begin
					count_r <= load_val;
				end else begin
					count_r <= count_r - 32'h1;
				end
			end
			if (underflow) begin
				flag_r <= 1'b1;
			end else if (kick | stop) begin
				flag_r <= 1'b0;
			end
			wdg_rst_r <= underflow & flag_r & res_en;
		end
	end
endmodule

// ==== dwt_top.v ====
// dual watchdog: software-started and always-on timers behind an avalon-mm slave
`timescale 1ns/10ps
`include "dwt_map.vh"
// Notes on behaviour
// - software counter ticks on divided bus clock; always-on counter on low-speed clock
// - software value read is exact; always-on value trusted only during debug halt
// - after reset software enables are clear, always-on enables are set
// - after reset software side is unlocked, always-on side is locked
// - open key on software key register unlocks all software registers
// - any other value on software key register locks them again
// - always-on: open key unlocks all but control; control key then unlocks control
// - partly unlocked always-on relocks on bad key, reload, control or second kick
// - fully unlocked always-on relocks on non-open key, reload, kick or control write
// - software kick register is 32 bits, always-on kick register is 8 bits
// - any software kick write clears; always-on needs a byte then its inverse
// - reload writes while software timer is idle leave the counter alone
// - setting irq_and_count_enable loads the counter and starts counting
// - a valid kick reloads the counter and counting continues
// - unkicked underflow raises the flag and reloads the counter
// - reload write while running replaces the counter at once
// - stop mode holds the software counter; it resumes from its held value
// - second underflow with flag set asserts reset and stops the software timer
// - always-on reload register resets to 0x0000ffff
// - clearing irq_and_count_enable stops the counter and clears the flag
module dwt_top (
	input wire CLOCK,
	input wire RESETN,
	input wire [7:0] AVS_ADDRESS,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire [31:0] AVS_WRITEDATA,
	input wire [3:0] AVS_BYTEENABLE,
	output wire [31:0] AVS_READDATA,
	output wire AVS_WAITREQUEST,
	input wire LOW_SPEED_COUNT_CLOCK,
	input wire STOP_MODE,
	input wire DEBUG_HALT,
	output wire SW_IRQ,
	output wire HW_IRQ,
	output wire SW_WDG_RESET,
	output wire HW_WDG_RESET
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function [31:0] merge_bytes;
		input [31:0] old_val;
		input [31:0] new_val;
		input [3:0] be;
		integer i;
		begin
			merge_bytes = old_val;
			for (i = 0; i < 4; i = i + 1) begin
				if (be[i]) begin
					merge_bytes[i*8 +: 8] = new_val[i*8 +: 8];
				end
			end
		end
	endfunction

	localparam [2:0] HW_LOCKED = 3'h1;
	localparam [2:0] HW_PART = 3'h2;
	localparam [2:0] HW_FULL = 3'h4;

	// ----------------------------------------
	// bus slave: one wait cycle per access
	// ----------------------------------------
	reg ack_r;
	reg [31:0] rdata_r;
	reg [31:0] rdata_nxt;
	wire req;
	wire wr;
	wire [7:0] offs;

	assign req = AVS_READ | AVS_WRITE;
	assign AVS_WAITREQUEST = req & ~ack_r;
	assign AVS_READDATA = rdata_r;
	// write acts only at the edge where waitrequest is low
	assign wr = AVS_WRITE & ack_r;
	assign offs = {AVS_ADDRESS[7:2], 2'h0};

	// ----------------------------------------
	// state
	// ----------------------------------------
	reg sw_locked_r;
	reg [31:0] sw_reload_value_r;
	reg [1:0] sw_enable_control_r;
	reg [2:0] hw_lock_r;
	reg [2:0] hw_lock_nxt;
	reg [31:0] hw_reload_value_r;
	reg [1:0] hw_enable_control_r;
	reg hw_kick_armed_r;
	reg [7:0] hw_kick_byte_r;
	reg [7:0] sw_div_r;
	reg lsc_s1_r;
	reg lsc_s2_r;
	reg lsc_s3_r;
	reg lsc_lvl_r;

	wire [31:0] sw_count;
	wire [31:0] hw_count;
	wire sw_flag;
	wire hw_flag;
	wire sw_rst;
	wire hw_rst;

	// ----------------------------------------
	// write decode
	// ----------------------------------------
	wire sw_open;
	wire wr_sw_reload;
	wire wr_sw_ctrl;
	wire wr_sw_kick;
	wire wr_sw_key;
	wire wr_hw_reload;
	wire wr_hw_ctrl;
	wire wr_hw_kick;
	wire wr_hw_key;
	wire hw_open;
	wire hw_kick_ok;
	wire [31:0] sw_reload_wdata;
	wire [31:0] hw_reload_wdata;

	assign sw_open = ~sw_locked_r;
	// writes to locked registers are dropped silently
	assign wr_sw_reload = wr & (offs == `DWT_SW_RELOAD) & sw_open;
	assign wr_sw_ctrl = wr & (offs == `DWT_SW_CTRL) & sw_open;
	assign wr_sw_kick = wr & (offs == `DWT_SW_KICK) & sw_open;
	assign wr_sw_key = wr & (offs == `DWT_SW_KEY);
	assign hw_open = ~hw_lock_r[0];
	assign wr_hw_reload = wr & (offs == `DWT_HW_RELOAD) & hw_open;
	assign wr_hw_ctrl = wr & (offs == `DWT_HW_CTRL) & hw_open;
	assign wr_hw_kick = wr & (offs == `DWT_HW_KICK) & hw_open;
	assign wr_hw_key = wr & (offs == `DWT_HW_KEY);
	// second byte must be the exact inverse of the first
	assign hw_kick_ok = wr_hw_kick & hw_lock_r[1] & hw_kick_armed_r &
		(AVS_WRITEDATA[`DWT_KICK_HW_MSB:0] == ~hw_kick_byte_r);
	assign sw_reload_wdata = merge_bytes(sw_reload_value_r, AVS_WRITEDATA, AVS_BYTEENABLE);
	assign hw_reload_wdata = merge_bytes(hw_reload_value_r, AVS_WRITEDATA, AVS_BYTEENABLE);

	// ----------------------------------------
	// software watchdog registers
	// ----------------------------------------
	wire sw_start;
	wire sw_stop;
	assign sw_start = wr_sw_ctrl & AVS_WRITEDATA[`DWT_CTRL_IRQ_BIT] & ~sw_enable_control_r[`DWT_CTRL_IRQ_BIT];
	assign sw_stop = wr_sw_ctrl & ~AVS_WRITEDATA[`DWT_CTRL_IRQ_BIT];

	always @(posedge CLOCK) begin
		if (!RESETN) begin
			sw_locked_r <= 1'b0;
			sw_reload_value_r <= `DWT_SW_RELOAD_RST;
			sw_enable_control_r <= `DWT_SW_CTRL_RST;
		end else begin
			if (wr_sw_key) begin
				sw_locked_r <= (AVS_WRITEDATA != `DWT_KEY_OPEN);
			end
			if (wr_sw_reload) begin
				sw_reload_value_r <= sw_reload_wdata;
			end
			if (sw_rst) begin
				sw_enable_control_r <= 2'h0;
			end else if (wr_sw_ctrl) begin
				sw_enable_control_r <= AVS_WRITEDATA[1:0];
			end
		end
	end

	// ----------------------------------------
	// software prescaler
	// ----------------------------------------
	wire sw_run;
	wire sw_tick;
	// stop mode and debug halt clear the divider to zero, so a full prescaler period passes before the first count after resume
	assign sw_run = sw_enable_control_r[`DWT_CTRL_IRQ_BIT] & ~STOP_MODE & ~DEBUG_HALT;
	assign sw_tick = (sw_div_r == (`DWT_SW_DIV - 8'h1));

	always @(posedge CLOCK) begin
		if (!RESETN) begin
			sw_div_r <= 8'h0;
		end else if (~sw_run | sw_tick) begin
			sw_div_r <= 8'h0;
		end else begin
			sw_div_r <= sw_div_r + 8'h1;
		end
	end

	wire sw_load;
	// idle reload writes only store the value
	assign sw_load = sw_start | wr_sw_kick |
		(wr_sw_reload & sw_enable_control_r[`DWT_CTRL_IRQ_BIT]);
	wire [31:0] sw_load_val;
	assign sw_load_val = wr_sw_reload ? sw_reload_wdata : sw_reload_value_r;

	dwt_core #(
		.INIT(`DWT_SW_RELOAD_RST)
	) u_sw (
		.clk(CLOCK),
		.rst_n(RESETN),
		.tick(sw_tick),
		.run(sw_run),
		.load(sw_load),
		.load_val(sw_load_val),
		.kick(wr_sw_kick),
		.stop(sw_stop | sw_rst),
		.res_en(sw_enable_control_r[`DWT_CTRL_RES_BIT]),
		.count_r(sw_count),
		.flag_r(sw_flag),
		.wdg_rst_r(sw_rst)
	);

	// ----------------------------------------
	// always-on lock sequencer
	// ----------------------------------------
	always @* begin
		hw_lock_nxt = hw_lock_r;
		case (hw_lock_r)
			HW_LOCKED: begin
				if (wr_hw_key & (AVS_WRITEDATA == `DWT_KEY_OPEN)) begin
					hw_lock_nxt = HW_PART;
				end
			end
			HW_PART: begin
				if (wr_hw_key) begin
					if (AVS_WRITEDATA == `DWT_KEY_CTRL) begin
						hw_lock_nxt = HW_FULL;
					end else if (AVS_WRITEDATA != `DWT_KEY_OPEN) begin
						hw_lock_nxt = HW_LOCKED;
					end
				end else if (wr_hw_reload | wr_hw_ctrl | (wr_hw_kick & hw_kick_armed_r)) begin
					hw_lock_nxt = HW_LOCKED;
				end
			end
			HW_FULL: begin
				if (wr_hw_key) begin
					hw_lock_nxt = (AVS_WRITEDATA == `DWT_KEY_OPEN) ? HW_PART : HW_LOCKED;
				end else if (wr_hw_reload | wr_hw_ctrl | wr_hw_kick) begin
					hw_lock_nxt = HW_LOCKED;
				end
			end
			default: begin
				hw_lock_nxt = HW_LOCKED;
			end
		endcase
	end

	// ----------------------------------------
	// always-on registers
	// ----------------------------------------
	wire hw_start;
	wire hw_stop;
	wire hw_ctrl_wr_ok;
	// control is written only when fully unlocked
	assign hw_ctrl_wr_ok = wr_hw_ctrl & hw_lock_r[2];
	assign hw_start = hw_ctrl_wr_ok & AVS_WRITEDATA[`DWT_CTRL_IRQ_BIT] & ~hw_enable_control_r[`DWT_CTRL_IRQ_BIT];
	assign hw_stop = hw_ctrl_wr_ok & ~AVS_WRITEDATA[`DWT_CTRL_IRQ_BIT];

	always @(posedge CLOCK) begin
		if (!RESETN) begin
			hw_lock_r <= HW_LOCKED;
			hw_reload_value_r <= `DWT_HW_RELOAD_RST;
			hw_enable_control_r <= `DWT_HW_CTRL_RST;
			hw_kick_armed_r <= 1'b0;
			hw_kick_byte_r <= 8'h0;
		end else begin
			hw_lock_r <= hw_lock_nxt;
			if (hw_rst) begin
				hw_reload_value_r <= `DWT_HW_RELOAD_RST;
			end else if (wr_hw_reload) begin
				hw_reload_value_r <= hw_reload_wdata;
			end
			if (hw_ctrl_wr_ok) begin
				hw_enable_control_r <= AVS_WRITEDATA[1:0];
			end
			if (wr_hw_kick & hw_lock_r[1] & ~hw_kick_armed_r) begin
				hw_kick_armed_r <= 1'b1;
				hw_kick_byte_r <= AVS_WRITEDATA[`DWT_KICK_HW_MSB:0];
			end else if (hw_lock_nxt != HW_PART) begin
				hw_kick_armed_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// low-speed clock sampling
	// ----------------------------------------
	wire hw_tick;
	wire hw_run;
	always @(posedge CLOCK) begin
		if (!RESETN) begin
			lsc_s1_r <= 1'b0;
			lsc_s2_r <= 1'b0;
			lsc_s3_r <= 1'b0;
			lsc_lvl_r <= 1'b0;
		end else begin
			lsc_s1_r <= LOW_SPEED_COUNT_CLOCK;
			lsc_s2_r <= lsc_s1_r;
			lsc_s3_r <= lsc_s2_r;
			if (lsc_s2_r == lsc_s3_r) begin
				lsc_lvl_r <= lsc_s3_r;
			end
		end
	end
	// one count per rising edge of the filtered low-speed clock
	assign hw_tick = (lsc_s2_r == lsc_s3_r) & lsc_s3_r & ~lsc_lvl_r;
	// debug halt freezes the count so a read is trustworthy
	assign hw_run = hw_enable_control_r[`DWT_CTRL_IRQ_BIT] & ~DEBUG_HALT & ~STOP_MODE;

	wire hw_load;
	assign hw_load = hw_start | hw_kick_ok | wr_hw_reload | hw_rst;
	wire [31:0] hw_load_val;
	assign hw_load_val = hw_rst ? `DWT_HW_RELOAD_RST : (wr_hw_reload ? hw_reload_wdata : hw_reload_value_r);

	dwt_core #(
		.INIT(`DWT_HW_RELOAD_RST)
	) u_hw (
		.clk(CLOCK),
		.rst_n(RESETN),
		.tick(hw_tick),
		.run(hw_run),
		.load(hw_load),
		.load_val(hw_load_val),
		.kick(hw_kick_ok),
		.stop(hw_stop),
		.res_en(hw_enable_control_r[`DWT_CTRL_RES_BIT]),
		.count_r(hw_count),
		.flag_r(hw_flag),
		.wdg_rst_r(hw_rst)
	);

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always @* begin
		rdata_nxt = 32'h0;
		case (offs)
			`DWT_SW_RELOAD: rdata_nxt = sw_reload_value_r;
			`DWT_SW_VALUE: rdata_nxt = sw_count;
			`DWT_SW_CTRL: rdata_nxt = {30'h0, sw_enable_control_r};
			`DWT_SW_FLAG: rdata_nxt = {31'h0, sw_flag};
			`DWT_SW_KEY: rdata_nxt = {31'h0, sw_locked_r};
			`DWT_HW_RELOAD: rdata_nxt = hw_reload_value_r;
			`DWT_HW_VALUE: rdata_nxt = hw_count;
			`DWT_HW_CTRL: rdata_nxt = {30'h0, hw_enable_control_r};
			`DWT_HW_FLAG: rdata_nxt = {31'h0, hw_flag};
			`DWT_HW_KEY: rdata_nxt = {30'h0, hw_lock_r[2], hw_lock_r[0]};
			default: rdata_nxt = 32'h0;
		endcase
	end

	always @(posedge CLOCK) begin
		if (!RESETN) begin
			ack_r <= 1'b0;
			rdata_r <= 32'h0;
		end else begin
			ack_r <= req & ~ack_r;
			if (AVS_READ & ~ack_r) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign SW_IRQ = sw_flag;
	assign HW_IRQ = hw_flag;
	assign SW_WDG_RESET = sw_rst;
	assign HW_WDG_RESET = hw_rst;
endmodule

// ==== dwt_props.sv ====
// checker: bus handshake and watchdog output properties of dwt_top
`timescale 1ns/10ps
module dwt_props (
	input wire CLOCK,
	input wire RESETN,
	input wire AVS_READ,
	input wire AVS_WRITE,
	input wire AVS_WAITREQUEST,
	input wire STOP_MODE,
	input wire DEBUG_HALT,
	input wire SW_IRQ,
	input wire HW_IRQ,
	input wire SW_WDG_RESET,
	input wire HW_WDG_RESET
);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RESETN);

	one_wait_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("bus request waited more than one cycle");
	sw_pulse_a: assert property (SW_WDG_RESET |=> !SW_WDG_RESET)
		else $error("software reset longer than one cycle");
	sw_rst_cause_a: assert property (SW_WDG_RESET |-> $past(SW_IRQ))
		else $error("software reset without pending flag");
	sw_rst_stop_a: assert property (SW_WDG_RESET |-> ##[1:3] !SW_IRQ)
		else $error("software reset did not stop the timer");
	hw_rst_cause_a: assert property (HW_WDG_RESET |-> $past(HW_IRQ))
		else $error("always-on reset without pending flag");
	// flag may only drop after a bus write or a watchdog reset
	sw_fall_a: assert property ($fell(SW_IRQ) |-> $past(AVS_WRITE) || SW_WDG_RESET || $past(SW_WDG_RESET))
		else $error("software flag dropped without cause");
	hw_fall_a: assert property ($fell(HW_IRQ) |-> $past(AVS_WRITE) || HW_WDG_RESET || $past(HW_WDG_RESET))
		else $error("always-on flag dropped without cause");
	stop_hold_a: assert property ($past(STOP_MODE) |-> !$rose(SW_IRQ))
		else $error("software flag rose in stop mode");
	halt_hold_a: assert property ($past(DEBUG_HALT) |-> !$rose(HW_IRQ) && !$rose(SW_IRQ))
		else $error("flag rose during debug halt");
endmodule

// ==== tb.sv ====
// testbench: register-level tests of dwt_top over avalon-mm
`timescale 1ns/10ps
`include "dwt_map.vh"
module tb;
	localparam [7:0] SRL = `DWT_SW_RELOAD, SVL = `DWT_SW_VALUE, SCT = `DWT_SW_CTRL, SKI = `DWT_SW_KICK;
	localparam [7:0] SFL = `DWT_SW_FLAG, SKY = `DWT_SW_KEY, HRL = `DWT_HW_RELOAD, HVL = `DWT_HW_VALUE;
	localparam [7:0] HCT = `DWT_HW_CTRL, HKI = `DWT_HW_KICK, HKY = `DWT_HW_KEY, HFL = `DWT_HW_FLAG;
	localparam [31:0] KO = `DWT_KEY_OPEN, KC = `DWT_KEY_CTRL;
	logic CLOCK = 1'b0;
	logic RESETN = 1'b0;
	logic AVS_READ = 1'b0, AVS_WRITE = 1'b0, LOW_SPEED_COUNT_CLOCK = 1'b0, STOP_MODE = 1'b0, DEBUG_HALT = 1'b0;
	logic [7:0] AVS_ADDRESS = 8'h00;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [31:0] rdv, v, w;
	logic [3:0] AVS_BYTEENABLE = 4'hf;
	wire [31:0] AVS_READDATA;
	wire AVS_WAITREQUEST, SW_IRQ, HW_IRQ, SW_WDG_RESET, HW_WDG_RESET;
	int n_fail = 0, tests_run = 0, cyc = 0;

	dwt_top i_dut (.CLOCK(CLOCK), .RESETN(RESETN), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
		.AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
		.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
		.LOW_SPEED_COUNT_CLOCK(LOW_SPEED_COUNT_CLOCK), .STOP_MODE(STOP_MODE), .DEBUG_HALT(DEBUG_HALT),
		.SW_IRQ(SW_IRQ), .HW_IRQ(HW_IRQ), .SW_WDG_RESET(SW_WDG_RESET), .HW_WDG_RESET(HW_WDG_RESET));

	// ----------------------------------------
	// clock, slow count clock, timeout
	// ----------------------------------------
	always #2.5 CLOCK = ~CLOCK;
	// slow clock: 8 cycles per level, well above the 2-cycle filter minimum
	always @(posedge CLOCK) begin
		cyc <= cyc + 1;
		if (cyc % 8 == 7) LOW_SPEED_COUNT_CLOCK <= ~LOW_SPEED_COUNT_CLOCK;
		if (cyc == 20000) begin
			n_fail++;
			stop_test();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ok(input logic c);
		chk({31'h0, c}, 32'h1);
	endtask
	// values read right after an edge are the pre-edge ones, as the slave saw them
	// no local limit: a hung slave is caught by the cycle ceiling
	task automatic bus(input logic wen, input logic [7:0] a, input logic [31:0] d);
		@(posedge CLOCK);
		AVS_WRITE <= wen;
		AVS_READ <= ~wen;
		AVS_ADDRESS <= a;
		AVS_WRITEDATA <= d;
		do begin
			@(posedge CLOCK);
		end while (AVS_WAITREQUEST !== 1'b0);
		rdv = AVS_READDATA;
		AVS_WRITE <= 1'b0;
		AVS_READ <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		bus(1'b0, a, 32'h0);
		v = rdv;
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(v, e);
	endtask
	task automatic waitfor(input int s, input int lim);
		int n;
		logic [3:0] sig;
		n = 0;
		do begin
			@(posedge CLOCK);
			n++;
			sig = {HW_WDG_RESET, HW_IRQ, SW_WDG_RESET, SW_IRQ};
		end while (sig[s] !== 1'b1 && n < lim);
		ok(sig[s]);
	endtask
	task automatic stop_test;
		$display("mismatches %0d of %0d checks", n_fail, tests_run);
		if (n_fail == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge CLOCK);
		RESETN <= 1'b1;
		rc(SCT, 32'h0);
		rc(SKY, 32'h0);
		rc(HCT, 32'h3);
		rc(HKY, 32'h1);
		rc(HRL, 32'h0000ffff);
		wr(SRL, 32'h40);
		rc(SVL, 32'hffffffff);
		wr(SKY, 32'h0);
		wr(SRL, 32'h99);
		wr(SCT, 32'h1);
		rc(SRL, 32'h40);
		rc(SCT, 32'h0);
		rc(SKY, 32'h1);
		wr(SKY, KO);
		rc(SKY, 32'h0);
		wr(SCT, 32'h1);
		rd(SVL);
		ok(v <= 32'h40 && v >= 32'h3c);
		w = v;
		repeat (40) @(posedge CLOCK);
		rd(SVL);
		ok(w - v >= 32'ha && w - v <= 32'hb);
		wr(SKI, 32'h0);
		rd(SVL);
		ok(v >= 32'h3e && v <= 32'h40);
		wr(SRL, 32'h8);
		rd(SVL);
		ok(v <= 32'h8);
		waitfor(0, 100);
		rc(SFL, 32'h1);
		wr(SKI, 32'h5);
		rc(SFL, 32'h0);
		waitfor(0, 100);
		wr(SCT, 32'h0);
		rc(SFL, 32'h0);
		rd(SVL);
		w = v;
		wr(SCT, 32'h2);
		repeat (60) @(posedge CLOCK);
		rc(SVL, w);
		chk(SW_IRQ, 1'b0);
		wr(SRL, 32'h100);
		wr(SCT, 32'h1);
		STOP_MODE <= 1'b1;
		rd(SVL);
		w = v;
		repeat (30) @(posedge CLOCK);
		rc(SVL, w);
		STOP_MODE <= 1'b0;
		repeat (20) @(posedge CLOCK);
		rd(SVL);
		ok(v < w && v + 32'h8 > w);
		wr(SRL, 32'h8);
		wr(SCT, 32'h3);
		waitfor(0, 100);
		waitfor(1, 100);
		rc(SCT, 32'h0);
		rc(SFL, 32'h0);
		wr(HRL, 32'h20);
		rc(HRL, 32'h0000ffff);
		wr(HKY, KC);
		rc(HKY, 32'h1);
		wr(HKY, KO);
		rc(HKY, 32'h0);
		wr(HCT, 32'h0);
		rc(HCT, 32'h3);
		rc(HKY, 32'h1);
		wr(HKY, KO);
		wr(HKY, 32'h5);
		rc(HKY, 32'h1);
		wr(HKY, KO);
		wr(HRL, 32'h40);
		rc(HRL, 32'h40);
		rc(HKY, 32'h1);
		repeat (100) @(posedge CLOCK);
		wr(HKY, KO);
		wr(HKI, 32'h5a);
		rc(HKY, 32'h0);
		wr(HKI, 32'h5b);
		rc(HKY, 32'h1);
		rd(HVL);
		ok(v <= 32'h3b);
		wr(HKY, KO);
		wr(HKI, 32'h1234005a);
		wr(HKI, 32'h000000a5);
		rd(HVL);
		ok(v >= 32'h3f && v <= 32'h40);
		rc(HKY, 32'h1);
		wr(HKY, KO);
		wr(HKY, KC);
		rc(HKY, 32'h2);
		wr(HKI, 32'h0);
		rc(HKY, 32'h1);
		wr(HKY, KO);
		wr(HKY, KC);
		wr(HCT, 32'h1);
		rc(HCT, 32'h1);
		rc(HKY, 32'h1);
		DEBUG_HALT <= 1'b1;
		rd(HVL);
		w = v;
		repeat (40) @(posedge CLOCK);
		rc(HVL, w);
		DEBUG_HALT <= 1'b0;
		wr(HKY, KO);
		wr(HRL, 32'h4);
		waitfor(2, 300);
		// reset enable off: later underflows must not reset the reload value
		repeat (120) @(posedge CLOCK);
		rc(HFL, 32'h1);
		rc(HRL, 32'h4);
		wr(HKY, KO);
		wr(HKI, 32'h3c);
		wr(HKI, 32'hc3);
		rc(HFL, 32'h0);
		chk(HW_IRQ, 1'b0);
		wr(HKY, KO);
		wr(HKY, KC);
		wr(HCT, 32'h3);
		waitfor(2, 300);
		waitfor(3, 300);
		rc(HRL, 32'h0000ffff);
		stop_test();
	end
endmodule

bind dwt_top dwt_props i_props (.CLOCK(CLOCK), .RESETN(RESETN), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_WAITREQUEST(AVS_WAITREQUEST), .STOP_MODE(STOP_MODE), .DEBUG_HALT(DEBUG_HALT), .SW_IRQ(SW_IRQ),
	.HW_IRQ(HW_IRQ), .SW_WDG_RESET(SW_WDG_RESET), .HW_WDG_RESET(HW_WDG_RESET));
